// [rtl/qcm_pkg.sv]
// Package of constants for the queue congestion monitor.
// Assumes a 32-bit APB register bus and a single 25 MHz clock.
package qcm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] EGR_CFG_OFS = 8'h00;
  localparam logic [7:0] EGR_TICKS_OFS = 8'h04;
  localparam logic [7:0] EGR_SCORE_OFS = 8'h08;
  localparam logic [7:0] ING_CFG_OFS = 8'h0C;
  localparam logic [7:0] ING_TICKS_OFS = 8'h10;
  localparam logic [7:0] ING_SCORE_OFS = 8'h14;
  localparam logic [7:0] REORDER_OFS = 8'h18;
  localparam logic [7:0] BIAS_OFS = 8'h1C;
  localparam logic [7:0] INT_STAT_OFS = 8'h20;
  localparam logic [7:0] INT_EN_OFS = 8'h24;
  localparam logic [7:0] INT_CLR_OFS = 8'h28;
  localparam logic [7:0] NOTIFY_OFS = 8'h2C;
  // ==========================================================
  // Field widths and positions
  localparam int CNT_W = 16;
  localparam int LVL_W = 8;
  localparam int LVL_LSB = 0;
  localparam int CONG_LSB = 8;
  localparam int LEAK_LSB = 16;
  localparam int IVL_W = 8;
  localparam int HI_LSB = 16;
  // Status bit positions.
  localparam int EGR_FLAG_BIT = 0;
  localparam int ING_FLAG_BIT = 1;
  localparam int RDR_FLAG_BIT = 2;
  localparam int NUM_FLAGS = 3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage

// [rtl/qcm_queue_score.sv]
// One leaky-bucket congestion scorer for a single queue.
// Assumes the tick enables are single-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module qcm_queue_score (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire logic [7:0] levelLimit,
  input wire logic [15:0] scoreLimit,
  // Events
  input wire logic pktDone,
  input wire logic [7:0] queueLevel,
  input wire logic congTick,
  input wire logic leakTick,
  input wire logic biasTick,
  input wire logic scoreClear,
  input wire logic countRead,
  // Results
  output logic [15:0] congestionScore,
  output logic [15:0] overLevelTickCount,
  output logic alarm
);
  logic [15:0] score_reg;
  logic [15:0] ticks_reg;
  logic [1:0] dec;
  logic inc;
  logic [17:0] sum;
  assign inc = pktDone && (queueLevel > levelLimit);
  assign dec = {1'b0, leakTick} + {1'b0, biasTick};
  assign sum = {2'b00, score_reg} + {17'h00000, inc} - {16'h0000, dec};

  // ==========================================================
  // Score update
  // Floor and saturate
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      score_reg <= qcm_pkg::CNT_ZERO;
    end else if (scoreClear) begin
      score_reg <= qcm_pkg::CNT_ZERO;
    end else if (sum[17]) begin
      score_reg <= qcm_pkg::CNT_ZERO;
    end else if (sum[16]) begin
      score_reg <= qcm_pkg::CNT_MAX;
    end else begin
      score_reg <= sum[15:0];
    end
  end

  // ==========================================================
  // Over-level ticks; a read and a tick together keep the tick.
  // Clear on read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ticks_reg <= qcm_pkg::CNT_ZERO;
    end else if (congTick && score_reg != qcm_pkg::CNT_ZERO) begin
      if (countRead) begin
        ticks_reg <= qcm_pkg::CNT_ONE;
      end else if (ticks_reg != qcm_pkg::CNT_MAX) begin
        ticks_reg <= ticks_reg + qcm_pkg::CNT_ONE;
      end
    end else if (countRead) begin
      ticks_reg <= qcm_pkg::CNT_ZERO;
    end
  end

  assign congestionScore = score_reg;
  assign overLevelTickCount = ticks_reg;
  assign alarm = score_reg > scoreLimit;

  chk_score_clear: assert property (@(posedge sys_clk) disable iff (rst)
    scoreClear |=> score_reg == qcm_pkg::CNT_ZERO)
    else $error("score not cleared");
  chk_tick_count: assert property (@(posedge sys_clk) disable iff (rst)
    congTick && score_reg != 16'h0000 && !countRead && ticks_reg != 16'hFFFF
    |=> ticks_reg == $past(ticks_reg) + 16'h0001)
    else $error("tick count missed");
  chk_ticks_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !countRead && !congTick |=> ticks_reg == $past(ticks_reg))
    else $error("tick count changed");
  chk_score_inc: assert property (@(posedge sys_clk) disable iff (rst)
    inc && !leakTick && !biasTick && !scoreClear && score_reg != 16'hFFFF
    |=> score_reg == $past(score_reg) + 16'h0001)
    else $error("score not raised");
endmodule
`default_nettype wire

// [rtl/qcm_monitor.sv]
// Per-port queue congestion monitor with APB registers and one interrupt.
// Assumes fabric event inputs are synchronous pulses on sys_clk.
//
// Summary of operation
// - Over-level tick count rises each congestion tick while score is nonzero.
// - Over-level tick count clears only when software reads it.
// - Score rises when egress queue level exceeds the level limit.
// - Level comparison happens only when a packet is fully received.
// - Leak tick timer decrements the score on every tick.
// - Error rate bias timer ticks also decrement the score.
// - Writing one to egress congestion flag clears the egress score.
// - Egress flag sets when score exceeds the score alarm limit.
// - Reorder count rises whenever fabric picks a non-head ingress packet.
// - Ingress reorder flag sets when reorder count reaches its limit.
// - A second identical scorer watches the ingress queue.
// - Status holds ingress and egress congestion flags per port.
// - Egress flag setting may trigger a notification packet request.
`timescale 1ns/1ps
`default_nettype none
module qcm_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Queue events
  input wire logic egressPktDone,
  input wire logic [7:0] egressLevel,
  input wire logic ingressPktDone,
  input wire logic [7:0] ingressLevel,
  input wire logic fabricReorder,
  // Notification and interrupt
  output logic notifyReq,
  output logic irq
);
  logic [31:0] egrCfg_reg;
  logic [31:0] ingCfg_reg;
  logic [31:0] egrLim_reg;
  logic [31:0] ingLim_reg;
  logic [31:0] rdrCfg_reg;
  logic [7:0] biasIvl_reg;
  logic [2:0] stat_reg;
  logic [2:0] en_reg;
  logic notifyEn_reg;
  logic [15:0] rdrCnt_reg;
  logic [31:0] prdata_reg;
  logic notify_reg;
  logic egrAlarm;
  logic ingAlarm;
  logic egrAlarmQ_reg;
  logic [2:0] setEv;
  logic [2:0] clrEv;
  logic wrEn;
  logic rdEn;
  logic egrCongTick, egrLeakTick, ingCongTick, ingLeakTick, biasTick;
  logic egrRd, ingRd;
  logic [15:0] egrScore, egrTicks, ingScore, ingTicks;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // Tick timers
  function automatic logic tickDue(input logic [7:0] cnt, input logic [7:0] ivl);
    tickDue = (cnt >= ivl);
  endfunction
  logic [7:0] egrCongCnt_reg, egrLeakCnt_reg, ingCongCnt_reg, ingLeakCnt_reg;
  logic [7:0] biasCnt_reg;
  assign egrCongTick = tickDue(egrCongCnt_reg, egrCfg_reg[qcm_pkg::CONG_LSB +: 8]);
  assign egrLeakTick = tickDue(egrLeakCnt_reg, egrCfg_reg[qcm_pkg::LEAK_LSB +: 8]);
  assign ingCongTick = tickDue(ingCongCnt_reg, ingCfg_reg[qcm_pkg::CONG_LSB +: 8]);
  assign ingLeakTick = tickDue(ingLeakCnt_reg, ingCfg_reg[qcm_pkg::LEAK_LSB +: 8]);
  assign biasTick = tickDue(biasCnt_reg, biasIvl_reg);

  // Timers restart from zero after reset.
  // Timer restart
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      egrCongCnt_reg <= 8'h00;
      egrLeakCnt_reg <= 8'h00;
      ingCongCnt_reg <= 8'h00;
      ingLeakCnt_reg <= 8'h00;
      biasCnt_reg <= 8'h00;
    end else begin
      egrCongCnt_reg <= egrCongTick ? 8'h00 : egrCongCnt_reg + 8'h01;
      egrLeakCnt_reg <= egrLeakTick ? 8'h00 : egrLeakCnt_reg + 8'h01;
      ingCongCnt_reg <= ingCongTick ? 8'h00 : ingCongCnt_reg + 8'h01;
      ingLeakCnt_reg <= ingLeakTick ? 8'h00 : ingLeakCnt_reg + 8'h01;
      biasCnt_reg <= biasTick ? 8'h00 : biasCnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      egrCfg_reg <= 32'h0000_0000;
      ingCfg_reg <= 32'h0000_0000;
      egrLim_reg <= 32'h0000_0000;
      ingLim_reg <= 32'h0000_0000;
      rdrCfg_reg <= 32'h0000_0000;
      biasIvl_reg <= 8'h00;
      en_reg <= 3'h0;
      notifyEn_reg <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        qcm_pkg::EGR_CFG_OFS: egrCfg_reg <= {8'h00, pwdata[23:0]};
        qcm_pkg::ING_CFG_OFS: ingCfg_reg <= {8'h00, pwdata[23:0]};
        qcm_pkg::EGR_SCORE_OFS: egrLim_reg <= {pwdata[31:16], 16'h0000};
        qcm_pkg::ING_SCORE_OFS: ingLim_reg <= {pwdata[31:16], 16'h0000};
        qcm_pkg::REORDER_OFS: rdrCfg_reg <= {pwdata[31:16], 16'h0000};
        qcm_pkg::BIAS_OFS: biasIvl_reg <= pwdata[7:0];
        qcm_pkg::INT_EN_OFS: en_reg <= pwdata[2:0];
        qcm_pkg::NOTIFY_OFS: notifyEn_reg <= pwdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Scorers for both queues
  assign egrRd = rdEn && paddr == qcm_pkg::EGR_TICKS_OFS;
  assign ingRd = rdEn && paddr == qcm_pkg::ING_TICKS_OFS;

  qcm_queue_score egrScorer (
    .sys_clk(sys_clk),
    .rst(rst),
    .levelLimit(egrCfg_reg[qcm_pkg::LVL_LSB +: 8]),
    .scoreLimit(egrLim_reg[qcm_pkg::HI_LSB +: 16]),
    .pktDone(egressPktDone),
    .queueLevel(egressLevel),
    .congTick(egrCongTick),
    .leakTick(egrLeakTick),
    .biasTick(biasTick),
    .scoreClear(clrEv[qcm_pkg::EGR_FLAG_BIT]),
    .countRead(egrRd),
    .congestionScore(egrScore),
    .overLevelTickCount(egrTicks),
    .alarm(egrAlarm)
  );

  qcm_queue_score ingScorer (
    .sys_clk(sys_clk),
    .rst(rst),
    .levelLimit(ingCfg_reg[qcm_pkg::LVL_LSB +: 8]),
    .scoreLimit(ingLim_reg[qcm_pkg::HI_LSB +: 16]),
    .pktDone(ingressPktDone),
    .queueLevel(ingressLevel),
    .congTick(ingCongTick),
    .leakTick(ingLeakTick),
    .biasTick(biasTick),
    .scoreClear(clrEv[qcm_pkg::ING_FLAG_BIT]),
    .countRead(ingRd),
    .congestionScore(ingScore),
    .overLevelTickCount(ingTicks),
    .alarm(ingAlarm)
  );

  // ==========================================================
  // Reorder counter
  // Count reorders
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdrCnt_reg <= qcm_pkg::CNT_ZERO;
    end else if (fabricReorder && rdrCnt_reg != qcm_pkg::CNT_MAX) begin
      rdrCnt_reg <= rdrCnt_reg + qcm_pkg::CNT_ONE;
    end
  end

  // ==========================================================
  // Interrupt status; a set in the clear cycle wins.
  // Egress, ingress and reorder flag events
  assign setEv[qcm_pkg::EGR_FLAG_BIT] = egrAlarm;
  assign setEv[qcm_pkg::ING_FLAG_BIT] = ingAlarm;
  assign setEv[qcm_pkg::RDR_FLAG_BIT] =
    rdrCnt_reg >= rdrCfg_reg[qcm_pkg::HI_LSB +: 16];
  assign clrEv = (wrEn && paddr == qcm_pkg::INT_CLR_OFS) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= (stat_reg & ~clrEv) | setEv;
    end
  end

  assign irq = |(stat_reg & en_reg);

  // ==========================================================
  // Notification request on the rising edge of the egress alarm.
  // Notify on egress flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      egrAlarmQ_reg <= 1'b0;
      notify_reg <= 1'b0;
    end else begin
      egrAlarmQ_reg <= egrAlarm;
      notify_reg <= notifyEn_reg && egrAlarm && !egrAlarmQ_reg;
    end
  end
  assign notifyReq = notify_reg;

  // ==========================================================
  // Read data, registered in the setup cycle so it is ready at access.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        qcm_pkg::EGR_CFG_OFS: prdata_reg <= egrCfg_reg;
        qcm_pkg::EGR_TICKS_OFS: prdata_reg <= {16'h0000, egrTicks};
        qcm_pkg::EGR_SCORE_OFS: prdata_reg <= {egrLim_reg[31:16], egrScore};
        qcm_pkg::ING_CFG_OFS: prdata_reg <= ingCfg_reg;
        qcm_pkg::ING_TICKS_OFS: prdata_reg <= {16'h0000, ingTicks};
        qcm_pkg::ING_SCORE_OFS: prdata_reg <= {ingLim_reg[31:16], ingScore};
        qcm_pkg::REORDER_OFS: prdata_reg <= {rdrCfg_reg[31:16], rdrCnt_reg};
        qcm_pkg::BIAS_OFS: prdata_reg <= {24'h000000, biasIvl_reg};
        qcm_pkg::INT_STAT_OFS: prdata_reg <= {29'h00000000, stat_reg};
        qcm_pkg::INT_EN_OFS: prdata_reg <= {29'h00000000, en_reg};
        qcm_pkg::NOTIFY_OFS: prdata_reg <= {31'h00000000, notifyEn_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_reg;

  // ==========================================================
  // Checks
  chk_reorder_flag: assert property (@(posedge sys_clk) disable iff (rst)
    rdrCnt_reg >= rdrCfg_reg[31:16] |=> stat_reg[2])
    else $error("reorder flag not set");
  chk_egress_flag: assert property (@(posedge sys_clk) disable iff (rst)
    egrScore > egrLim_reg[31:16] |=> stat_reg[0])
    else $error("egress flag not set");
  chk_reorder_inc: assert property (@(posedge sys_clk) disable iff (rst)
    fabricReorder && rdrCnt_reg != 16'hFFFF |=> rdrCnt_reg == $past(rdrCnt_reg) + 16'h0001)
    else $error("reorder not counted");
  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
    clrEv[0] && !egrAlarm |=> !stat_reg[0])
    else $error("egress flag not cleared");
endmodule
`default_nettype wire

// [tb/qcm_monitor_tb.sv]
// Self-checking testbench for the queue congestion monitor.
// Assumes the design files under rtl/ are compiled first; drives APB and events itself.
`timescale 1ns/1ps
`default_nettype none
module qcm_monitor_tb;
  // ==========================================================
  // Signals
  logic sysClk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic egressPktDone;
  logic [7:0] egressLevel;
  logic ingressPktDone;
  logic [7:0] ingressLevel;
  logic fabricReorder;
  logic notifyReq;
  logic irq;
  int miscompares = 0;
  int testsRun = 0;
  int notifyCount = 0;
  logic [31:0] rdata;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} qcm_row_t;
  qcm_row_t rows [11];

  qcm_monitor i_dut (.sys_clk(sysClk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .egressPktDone(egressPktDone), .egressLevel(egressLevel),
    .ingressPktDone(ingressPktDone), .ingressLevel(ingressLevel),
    .fabricReorder(fabricReorder), .notifyReq(notifyReq), .irq(irq));

  // ==========================================================
  // Clock, watchdog and notification monitor
  initial begin
    sysClk = 1'b0;
    forever #20 sysClk = ~sysClk;
  end
  initial begin
    repeat (100000) @(posedge sysClk);
    miscompares++;
    stopTest();
  end
  always @(posedge sysClk) begin
    if (notifyReq === 1'b1) notifyCount++;
  end

  // ==========================================================
  // Tasks
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Timer phase against the stimulus is not visible, so tick-driven values get a window.
  task automatic chkr(input string nm, input int lo, input int hi, input logic [31:0] g);
    testsRun++;
    if ((^g === 1'bX) || g < lo || g > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      stopTest();
    end
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sysClk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input int k, input logic [7:0] lvl);
    if (k == 0) begin egressLevel <= lvl; egressPktDone <= 1'b1; end
    if (k == 1) begin ingressLevel <= lvl; ingressPktDone <= 1'b1; end
    if (k == 2) fabricReorder <= 1'b1;
    @(posedge sysClk);
    egressPktDone <= 1'b0;
    ingressPktDone <= 1'b0;
    fabricReorder <= 1'b0;
    @(posedge sysClk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {egressPktDone, egressLevel, ingressPktDone, ingressLevel, fabricReorder} = '0;
    rows = '{'{qcm_pkg::EGR_TICKS_OFS, 32'h0000_1234, 32'h0000_0000},
      '{qcm_pkg::INT_STAT_OFS, 32'h0000_0007, 32'h0000_0000},
      '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000},
      '{qcm_pkg::BIAS_OFS, 32'h0000_00FF, 32'h0000_00FF},
      '{qcm_pkg::INT_EN_OFS, 32'h0000_0001, 32'h0000_0001},
      '{qcm_pkg::NOTIFY_OFS, 32'h0000_0001, 32'h0000_0001},
      '{qcm_pkg::EGR_SCORE_OFS, 32'h0002_0000, 32'h0002_0000},
      '{qcm_pkg::ING_SCORE_OFS, 32'h0001_0000, 32'h0001_0000},
      '{qcm_pkg::REORDER_OFS, 32'h0003_0000, 32'h0003_0000},
      '{qcm_pkg::EGR_CFG_OFS, 32'h00FF_0304, 32'h00FF_0304},
      '{qcm_pkg::ING_CFG_OFS, 32'h00FF_FF08, 32'h00FF_FF08}};
    repeat (16) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    chk("irq after reset", 32'h0, {31'h0, irq});
    // A zero reorder limit counts as reached, so the reorder flag is set straight out of reset.
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("reset value", (rows[i].a == qcm_pkg::INT_STAT_OFS) ? 32'h4 : 32'h0, rdata);
      apb(1'b1, rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("readback", (rows[i].a == qcm_pkg::INT_STAT_OFS) ? 32'h4 : rows[i].e, rdata);
    end
    apb(1'b1, qcm_pkg::INT_CLR_OFS, 32'h0000_0004);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("reorder flag cleared", 32'h0, rdata);
    $display("test register table done");
    // Level equal to the limit, or a high level without a completed packet, adds nothing.
    pulse(0, 8'h04);
    egressLevel <= 8'h05;
    repeat (4) @(posedge sysClk);
    rd(qcm_pkg::EGR_SCORE_OFS);
    chk("egress score idle", 32'h0002_0000, rdata);
    for (int i = 0; i < 6; i++) pulse(0, 8'h05);
    rd(qcm_pkg::EGR_SCORE_OFS);
    chkr("egress score", 32'h0002_0004, 32'h0002_0006, rdata);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status egress", 32'h1, rdata);
    chk("irq egress", 32'h1, {31'h0, irq});
    chk("notify count", 32'h1, notifyCount);
    $display("test egress score done");
    rd(qcm_pkg::EGR_TICKS_OFS);
    repeat (40) @(posedge sysClk);
    rd(qcm_pkg::EGR_TICKS_OFS);
    chkr("over-level ticks", 9, 12, rdata);
    rd(qcm_pkg::EGR_TICKS_OFS);
    chkr("ticks after read", 0, 1, rdata);
    $display("test tick count done");
    apb(1'b1, qcm_pkg::INT_CLR_OFS, 32'h0000_0001);
    rd(qcm_pkg::EGR_SCORE_OFS);
    chk("score cleared", 32'h0002_0000, rdata);
    // The alarm still held in the clearing cycle, and a set wins, so clear once more.
    apb(1'b1, qcm_pkg::INT_CLR_OFS, 32'h0000_0001);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status cleared", 32'h0, rdata);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // A score equal to the alarm limit must not raise the flag.
    pulse(0, 8'h05);
    pulse(0, 8'h05);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status at limit", 32'h0, rdata);
    repeat (600) @(posedge sysClk);
    rd(qcm_pkg::EGR_SCORE_OFS);
    chk("score leaked to floor", 32'h0002_0000, rdata);
    $display("test clear and leak done");
    for (int i = 0; i < 4; i++) pulse(1, 8'h09);
    rd(qcm_pkg::ING_SCORE_OFS);
    chkr("ingress score", 32'h0001_0002, 32'h0001_0004, rdata);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status ingress", 32'h2, rdata);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test ingress score done");
    pulse(2, 8'h00);
    pulse(2, 8'h00);
    rd(qcm_pkg::REORDER_OFS);
    chk("reorder count", 32'h0003_0002, rdata);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status below limit", 32'h2, rdata);
    pulse(2, 8'h00);
    rd(qcm_pkg::REORDER_OFS);
    chk("reorder count", 32'h0003_0003, rdata);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status reorder", 32'h6, rdata);
    apb(1'b1, qcm_pkg::INT_EN_OFS, 32'h0000_0004);
    chk("irq reorder", 32'h1, {31'h0, irq});
    $display("test reorder done");
    rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    chk("irq after reset", 32'h0, {31'h0, irq});
    rd(qcm_pkg::REORDER_OFS);
    chk("reorder after reset", 32'h0, rdata);
    rd(qcm_pkg::INT_STAT_OFS);
    chk("status after reset", 32'h4, rdata);
    rd(qcm_pkg::ING_SCORE_OFS);
    chk("score after reset", 32'h0, rdata);
    $display("test mid-run reset done");
    stopTest();
  end
endmodule
`default_nettype wire
